// ---- rtl/cbat_core.sv ----
// carry/borrow arithmetic slice: accumulator, carry flag and timing control
// assumes requests come from logic on the same core clock; operands are captured
`timescale 1ns/1ps
module cbat_core (
   input wire logic clk, // 20 MHz core clock
   input wire logic rst, // synchronous reset, active high
   input wire logic reqValid, // start one instruction
   input wire cbat_pkg::cbat_req_t req, // instruction and operands
   output logic reqReady, // ready to take a request
   output cbat_pkg::cbat_res_t state, // accumulator and carry
   output logic done, // one-cycle pulse at completion
   output logic [1:0] instrLen // code bytes of the last instruction
);
   import cbat_pkg::*;

   typedef enum logic {IDLE, EXEC} cbat_state_t;

   // clocks spent by the edge that takes a request
   localparam logic [1:0] FIRST_CLK = 2'h1;

   // sequencer state: phase and clocks spent on the running form
   cbat_state_t fsm_q, fsm_d;
   logic [1:0] cnt_q, cnt_d;

   // capture: the request kept for the later clocks of a form
   cbat_req_t held_q, held_d;

   // architectural state: accumulator and the single carry flag
   logic [7:0] acc_q, acc_d;
   logic carry_q, carry_d;

   // retirement marks: completion pulse and code length
   logic done_q, done_d;
   logic [1:0] len_q, len_d;

   // datapath and decode nets
   cbat_req_t active;
   logic [3:0] srcHot;
   logic [7:0] operand;
   logic [7:0] sum;
   logic carryOut;
   logic [1:0] formLen;
   logic [1:0] formCyc;
   logic [1:0] cntNext;
   logic take;
   logic retire;

   // live request while idle, captured request while later clocks run
   assign active = (fsm_q == EXEC) ? held_q : req;

   // one request at a time; refused while a form is still running
   assign reqReady = (fsm_q == IDLE);
   assign take = reqValid && reqReady;

   // code length of the form now in the datapath
   always_comb begin
      unique case (active.src)
         SRC_WORKING_REG: formLen = LEN_WORKING_REG;
         SRC_DIRECT: formLen = LEN_DIRECT;
         SRC_POINTER_IND: formLen = LEN_POINTER_IND;
         SRC_IMMEDIATE: formLen = LEN_IMMEDIATE;
      endcase
   end

   // clocks that the form now in the datapath needs
   always_comb begin
      unique case (active.src)
         SRC_WORKING_REG: formCyc = CYC_WORKING_REG;
         SRC_DIRECT: formCyc = CYC_DIRECT;
         SRC_POINTER_IND: formCyc = CYC_POINTER_IND;
         SRC_IMMEDIATE: formCyc = CYC_IMMEDIATE;
      endcase
   end

   // one-hot source decode for the operand multiplexer
   always_comb begin
      srcHot = 4'h0;
      unique case (active.src)
         SRC_WORKING_REG: srcHot[0] = 1'b1;
         SRC_DIRECT: srcHot[1] = 1'b1;
         SRC_POINTER_IND: srcHot[2] = 1'b1;
         SRC_IMMEDIATE: srcHot[3] = 1'b1;
      endcase
   end

   // operand multiplexer: one and-or gate per bit
   for (genvar i = 0; i < DATA_W; i++) begin : g_operand
      assign operand[i] = |(srcHot & {active.immediate[i], active.indirectByte[i],
         active.directByte[i], active.workingReg[i]});
   end

   // add or subtract with the one flag as carry in and borrow in
   cbat_adder u_adder (
      .acc(acc_q),
      .operand(operand),
      .carryIn(carry_q),
      .subtract(active.subtract),
      .result(sum),
      .carryOut(carryOut)
   );

   // clocks spent once the current clock ends; forms need at most two
   assign cntNext = cnt_q + FIRST_CLK;

   // retire on the last clock of the form: at once, or when its count is up
   always_comb begin
      retire = 1'b0;
      unique case (fsm_q)
         IDLE: retire = take && (formCyc == FIRST_CLK);
         EXEC: retire = (cntNext == formCyc);
      endcase
   end

   // sequencer: enter the later clocks, count them, return to idle
   always_comb begin
      fsm_d = fsm_q;
      cnt_d = cnt_q;
      unique case (fsm_q)
         IDLE: begin
            if (take) begin
               cnt_d = FIRST_CLK;
               if (!retire) begin
                  fsm_d = EXEC;
               end
            end
         end
         EXEC: begin
            cnt_d = cntNext;
            if (retire) begin
               fsm_d = IDLE;
            end
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge clk) begin
      if (rst) begin
         fsm_q <= IDLE;
         cnt_q <= 2'h0;
      end else begin
         fsm_q <= fsm_d;
         cnt_q <= cnt_d;
      end
   end

   // capture: operands kept for the later clocks of a form
   always_comb begin
      held_d = held_q;
      if (take) begin
         held_d = req;
      end
   end

   // capture register
   always_ff @(posedge clk) begin
      if (rst) begin
         held_q <= '0;
      end else begin
         held_q <= held_d;
      end
   end

   // accumulator: takes the result only when a form retires
   always_comb begin
      acc_d = acc_q;
      if (retire) begin
         acc_d = sum;
      end
   end

   // accumulator register
   always_ff @(posedge clk) begin
      if (rst) begin
         acc_q <= ACC_RESET;
      end else begin
         acc_q <= acc_d;
      end
   end

   // carry flag: carry out of an addition, borrow out of a subtraction
   always_comb begin
      carry_d = carry_q;
      if (retire) begin
         carry_d = carryOut;
      end
   end

   // carry flag register
   always_ff @(posedge clk) begin
      if (rst) begin
         carry_q <= CARRY_RESET;
      end else begin
         carry_q <= carry_d;
      end
   end

   // retirement marks: one-cycle pulse and the length of that form
   always_comb begin
      done_d = 1'b0;
      len_d = len_q;
      if (retire) begin
         done_d = 1'b1;
         len_d = formLen;
      end
   end

   // retirement mark registers
   always_ff @(posedge clk) begin
      if (rst) begin
         done_q <= 1'b0;
         len_q <= 2'h0;
      end else begin
         done_q <= done_d;
         len_q <= len_d;
      end
   end

   // outputs straight from the registers
   assign state = '{acc: acc_q, carry: carry_q};
   assign done = done_q;
   assign instrLen = len_q;
endmodule

// ---- rtl/cbat_pkg.sv ----
// constants, opcodes and carrier types of the carry/borrow arithmetic slice
// assumes one 20 MHz core clock and a synchronous active-high reset
// Functional notes
// - add-with-carry from working register: 1 byte, 1 clock.
// - add-with-carry from direct byte: 2 bytes, 2 clocks.
// - add-with-carry from pointer indirect RAM: 1 byte, 2 clocks.
// - add-with-carry from immediate: 2 bytes, 2 clocks.
// - subtract-with-borrow working register: 1 byte, 1 clock.
// - subtract-with-borrow direct byte: 2 bytes, 2 clocks.
// - subtract-with-borrow pointer indirect RAM: 1 byte, 2 clocks.
// - subtract-with-borrow immediate: 2 bytes, 2 clocks.
package cbat_pkg;
   localparam int CLK_HZ = 20000000;
   localparam int DATA_W = 8;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic CARRY_RESET = 1'b0;
   // source selectors
   typedef enum logic [1:0] {
      SRC_WORKING_REG,
      SRC_DIRECT,
      SRC_POINTER_IND,
      SRC_IMMEDIATE
   } cbat_src_t;
   // instruction lengths in bytes and execution times in clocks
   localparam logic [1:0] LEN_WORKING_REG = 2'h1;
   localparam logic [1:0] LEN_DIRECT = 2'h2;
   localparam logic [1:0] LEN_POINTER_IND = 2'h1;
   localparam logic [1:0] LEN_IMMEDIATE = 2'h2;
   localparam logic [1:0] CYC_WORKING_REG = 2'h1;
   localparam logic [1:0] CYC_DIRECT = 2'h2;
   localparam logic [1:0] CYC_POINTER_IND = 2'h2;
   localparam logic [1:0] CYC_IMMEDIATE = 2'h2;
   // one arithmetic request
   typedef struct packed {
      logic subtract; // 1 = subtract_with_borrow, 0 = add_with_carry
      cbat_src_t src;
      logic [7:0] workingReg; // working_register value
      logic [7:0] directByte; // byte from direct address
      logic [7:0] indirectByte; // pointer_indirect_ram byte
      logic [7:0] immediate; // constant from instruction stream
   } cbat_req_t;
   // architectural result
   typedef struct packed {
      logic [7:0] acc;
      logic carry;
   } cbat_res_t;
endpackage

// ---- rtl/cbat_adder.sv ----
// 8-bit add/subtract with carry or borrow in and out
// assumes operands are stable in the cycle they are used
`timescale 1ns/1ps
module cbat_adder (
   input wire logic [7:0] acc, // accumulator
   input wire logic [7:0] operand, // selected operand
   input wire logic carryIn, // carry or borrow flag
   input wire logic subtract, // 1 selects subtraction
   output logic [7:0] result, // 8-bit result
   output logic carryOut // carry out or borrow out
);
   import cbat_pkg::*;
   logic [8:0] wide;
   // subtraction borrows when acc < operand + borrow
   always_comb begin
      if (subtract) begin
         wide = {1'b0, acc} - {1'b0, operand} - {8'h00, carryIn};
      end else begin
         wide = {1'b0, acc} + {1'b0, operand} + {8'h00, carryIn};
      end
      result = wide[7:0];
      carryOut = wide[8];
   end
endmodule

// ---- test/cbat_core_properties.sv ----
// timing checks on cbat_core, one per instruction form
// assumes one core clock and the synchronous reset of the core
`timescale 1ns/1ps
module cbat_core_properties (
   input wire logic clk, // core clock
   input wire logic rst, // sync reset
   input wire logic reqValid, // request strobe
   input wire cbat_pkg::cbat_req_t req, // request
   input wire logic reqReady, // ready
   input wire cbat_pkg::cbat_res_t state, // acc and carry
   input wire logic done, // completion pulse
   input wire logic [1:0] instrLen // code bytes
);
   import cbat_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // request kind and take strobe
   wire [2:0] k = {req.subtract, req.src};
   wire tk = reqValid && reqReady;
   property p_r1; tk && k == 3'h0 |=> done && instrLen == 2'h1; endproperty
   a_r1: assert property (p_r1) else $error("add reg timing");
   property p_r2; tk && k == 3'h1 |=> !done ##1 done && instrLen == 2'h2; endproperty
   a_r2: assert property (p_r2) else $error("add direct timing");
   property p_r3; tk && k == 3'h2 |=> !done ##1 done && instrLen == 2'h1; endproperty
   a_r3: assert property (p_r3) else $error("add pointer timing");
   property p_r4; tk && k == 3'h3 |=> !reqReady ##1 done && instrLen == 2'h2; endproperty
   a_r4: assert property (p_r4) else $error("add immediate timing");
   property p_r5; tk && k == 3'h4 |=> done && instrLen == 2'h1; endproperty
   a_r5: assert property (p_r5) else $error("sub reg timing");
   property p_r6; tk && k == 3'h5 |=> !done ##1 done && instrLen == 2'h2; endproperty
   a_r6: assert property (p_r6) else $error("sub direct timing");
   property p_r7; tk && k == 3'h6 |=> !reqReady ##1 done && instrLen == 2'h1; endproperty
   a_r7: assert property (p_r7) else $error("sub pointer timing");
   property p_r8; tk && k == 3'h7 |=> !done ##1 done && instrLen == 2'h2; endproperty
   a_r8: assert property (p_r8) else $error("sub immediate timing");
   property p_r9; !done && !$past(rst) |-> $stable(state); endproperty
   a_r9: assert property (p_r9) else $error("state moved without retire");
endmodule
bind cbat_core cbat_core_properties chk (.clk(clk), .rst(rst), .reqValid(reqValid), .req(req),
   .reqReady(reqReady), .state(state), .done(done), .instrLen(instrLen));

// ---- test/carry_borrow_arith_timing_tb.sv ----
// self-checking bench for cbat_core with corner and random traffic
// inputs change 1 ns after rising edges; request held high back to back
`timescale 1ns/1ps
module carry_borrow_arith_timing_tb;
   import cbat_pkg::*;
   logic clk = 1'b0, rst = 1'b1, reqValid = 1'b0;
   cbat_req_t req = '0;
   logic reqReady, done;
   cbat_res_t state;
   logic [1:0] instrLen;
   logic [8:0] m = '0; // model {carry, acc}
   logic [31:0] r; // random draw
   int n_fail = 0, checks = 0, cyc = 0, seed = 32'h0a5db9ab;
   cbat_core uut (.clk(clk), .rst(rst), .reqValid(reqValid), .req(req),
      .reqReady(reqReady), .state(state), .done(done), .instrLen(instrLen));
   // clock
   initial begin
      forever #25 clk = ~clk;
   end
   // hang ceiling
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_fail++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %0t %h %h", $time, seen, exp);
      end
   endtask
   // expected {carry, acc}; one flag is carry in and borrow in
   function automatic logic [8:0] calc(logic [8:0] x, logic s, logic [7:0] v);
      return s ? {1'b0, x[7:0]} - {1'b0, v} - {8'h00, x[8]}
         : {1'b0, x[7:0]} + {1'b0, v} + {8'h00, x[8]};
   endfunction
   // expected code length per source
   function automatic logic [1:0] lenOf(cbat_src_t k);
      case (k)
         SRC_DIRECT: return LEN_DIRECT;
         SRC_POINTER_IND: return LEN_POINTER_IND;
         SRC_IMMEDIATE: return LEN_IMMEDIATE;
         default: return LEN_WORKING_REG;
      endcase
   endfunction
   // one instruction; operand fields packed reg, direct, pointer, immediate
   task automatic op(logic s, cbat_src_t k, logic [31:0] d);
      reqValid = 1'b1;
      req = {s, k, d};
      m = calc(m, s, d[31-8*k -: 8]);
      @(posedge clk) #1;
      if (k != SRC_WORKING_REG) begin
         check(16'({reqReady, done}), 16'h0000);
         @(posedge clk) #1;
      end
      check(16'(done), 16'h0001);
      check(16'({state.carry, state.acc}), 16'(m));
      check(16'(instrLen), 16'(lenOf(k)));
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      #1 rst = 0;
      check(16'({reqReady, done, state.carry, state.acc, instrLen}), 16'h1000);
      op(1'b0, SRC_WORKING_REG, 32'hFF000000);
      op(1'b0, SRC_IMMEDIATE, 32'h00000001);
      op(1'b1, SRC_DIRECT, 32'h00000000);
      op(1'b1, SRC_POINTER_IND, 32'h0000FF00);
      $display("corner test done");
      // mid-run reset clears the result and the marks
      rst = 1'b1;
      reqValid = 1'b0;
      @(posedge clk) #1;
      rst = 1'b0;
      m = '0;
      check(16'({reqReady, done, state.carry, state.acc, instrLen}), 16'h1000);
      $display("reset test done");
      repeat (300) begin
         r = $random(seed);
         op(r[31], cbat_src_t'(r[5:4]), $random(seed));
      end
      reqValid = 1'b0;
      $display("random test done");
      test_done();
   end
endmodule
